// ### shared/pmfr_pkg.sv
// How it works
// - reserved bits read zero, writes harmless
// - ignored bits may read either value
// - write-only bit acts on a one
// - never block accesses to other devices
// - single writes update registers, no pairs
// - free-running 24-bit timer, no control
// - four-second button hold forces power off
// - wake alarm always present, status bit optional
// - controller event sits in general-purpose status
// - mode select bit shows legacy/advanced model
// - included fixed features behave exactly defined
// - status set by event, cleared by one
// - mode clear routes to SMI, set SCI
package pmfr_pkg;
    localparam int FIX_W = 16;
    localparam int GPE_W = 8;
    localparam int TMR_W = 24;
    // fixed status / enable bit positions
    localparam int FIX_TMR = 0;
    localparam int FIX_PWRBTN = 8;
    localparam int FIX_SLPBTN = 9;
    localparam int FIX_RTC = 10;
    localparam int FIX_WAK = 15;
    localparam logic [FIX_W-1:0] FIX_STS_IMPL = 16'h8701;
    localparam logic [FIX_W-1:0] FIX_EN_IMPL = 16'h0701;
    // control register layout
    localparam int CTL_MODE = 0;
    localparam int CTL_SLPTYP_LO = 10;
    localparam int CTL_SLPTYP_W = 3;
    localparam int CTL_SLPEN = 13;
    localparam logic [FIX_W-1:0] CTL_STORE_MASK = 16'h1c01;
    localparam logic [FIX_W-1:0] CTL_RESET = 16'h0000;
    // general-purpose bit that carries the embedded controller event
    localparam int GPE_EC = 0;
    localparam logic [GPE_W-1:0] GPE_RESET = 8'h00;
    localparam logic [FIX_W-1:0] FIX_RESET = 16'h0000;
    // timing
    localparam longint CLK_HZ = 200000000;
    localparam longint OVR_TIME_MS = 4000;
    localparam longint TICK_TIME_MS = 1;
    localparam longint TICK_CYCLES = (CLK_HZ * TICK_TIME_MS) / 1000;
    localparam int TMR_DIV_CYCLES = 56;

    typedef struct packed {
        logic strobe;
        logic [FIX_W-1:0] data;
    } pmfr_wr16_s;

    typedef struct packed {
        logic strobe;
        logic [GPE_W-1:0] data;
    } pmfr_wr8_s;

    typedef enum logic [1:0] {
        OVR_IDLE,
        OVR_COUNT,
        OVR_OFF
    } pmfr_ovr_e;
endpackage

// ### rtl/pmfr_status_cell.sv
`timescale 1ns/1ps
module pmfr_status_cell (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic eventIn,
    input wire logic clearOne,
    output logic status
);
    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status <= 1'b0;
        end else if (eventIn) begin
            status <= 1'b1;
        end else if (clearOne) begin
            status <= 1'b0;
        end
    end
endmodule

// ### rtl/pmfr_timer.sv
`timescale 1ns/1ps
module pmfr_timer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic [pmfr_pkg::TMR_W-1:0] count,
    output logic carryPulse
);
    logic [7:0] divCount;
    logic tick;

    // prescaler gives the timer its own slower rate as an enable pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            divCount <= 8'h00;
        end else if (divCount == 8'(pmfr_pkg::TMR_DIV_CYCLES - 1)) begin
            divCount <= 8'h00;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end
    assign tick = (divCount == 8'(pmfr_pkg::TMR_DIV_CYCLES - 1));

    // no start, stop or load input exists, so software cannot stall it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // the top bit flipping is reported as a timer event
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            carryPulse <= 1'b0;
        end else begin
            carryPulse <= tick && (count[pmfr_pkg::TMR_W-2:0] == '1);
        end
    end
endmodule

// ### rtl/pmfr_top.sv
`timescale 1ns/1ps
module pmfr_top #(
    parameter longint TICK_CYCLES = pmfr_pkg::TICK_CYCLES,
    parameter longint OVR_TICKS = pmfr_pkg::OVR_TIME_MS / pmfr_pkg::TICK_TIME_MS,
    parameter logic ACPI_ONLY = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pwrBtnPressed,
    input wire logic pwrBtnEvent,
    input wire logic slpBtnEvent,
    input wire logic rtcAlarmEvent,
    input wire logic wakeEvent,
    input wire logic ecEvent,
    input wire logic [pmfr_pkg::GPE_W-1:0] gpeEvents,
    input pmfr_pkg::pmfr_wr16_s fixStsWr,
    input pmfr_pkg::pmfr_wr16_s fixEnWr,
    input pmfr_pkg::pmfr_wr16_s ctlWr,
    input pmfr_pkg::pmfr_wr8_s gpeStsWr,
    input pmfr_pkg::pmfr_wr8_s gpeEnWr,
    output logic [pmfr_pkg::FIX_W-1:0] fixSts,
    output logic [pmfr_pkg::FIX_W-1:0] fixEn,
    output logic [pmfr_pkg::FIX_W-1:0] ctlRead,
    output logic [pmfr_pkg::GPE_W-1:0] gpeSts,
    output logic [pmfr_pkg::GPE_W-1:0] gpeEn,
    output logic [pmfr_pkg::TMR_W-1:0] timerValue,
    output logic acpi_mode_select,
    output logic [pmfr_pkg::CTL_SLPTYP_W-1:0] sleepType,
    output logic sleepStart,
    output logic rtcWake,
    output logic forceOff,
    output logic smiReq,
    output logic sciReq
);
    logic [pmfr_pkg::FIX_W-1:0] fixEvents;
    logic [pmfr_pkg::FIX_W-1:0] fixStsRaw;
    logic [pmfr_pkg::GPE_W-1:0] gpeAll;
    logic [pmfr_pkg::FIX_W-1:0] ctlReg;
    logic [pmfr_pkg::FIX_W-1:0] fixEnReg;
    logic [pmfr_pkg::GPE_W-1:0] gpeEnReg;
    logic [pmfr_pkg::GPE_W-1:0] gpeStsRaw;
    logic tmrCarry;
    logic anyEvent;
    logic [31:0] tickCount;
    logic msTick;
    logic [31:0] holdTicks;
    pmfr_pkg::pmfr_ovr_e ovrState;
    pmfr_pkg::pmfr_ovr_e next_ovrState;

    pmfr_timer u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .count(timerValue),
        .carryPulse(tmrCarry)
    );

    // fixed event inputs placed at their bit positions; others stay low
    always_comb begin
        fixEvents = '0;
        fixEvents[pmfr_pkg::FIX_TMR] = tmrCarry;
        fixEvents[pmfr_pkg::FIX_PWRBTN] = pwrBtnEvent;
        fixEvents[pmfr_pkg::FIX_SLPBTN] = slpBtnEvent;
        fixEvents[pmfr_pkg::FIX_RTC] = rtcAlarmEvent;
        fixEvents[pmfr_pkg::FIX_WAK] = wakeEvent;
    end

    // the controller event is ORed with gpeEvents[0] into general-purpose status bit GPE_EC
    always_comb begin
        gpeAll = gpeEvents;
        gpeAll[pmfr_pkg::GPE_EC] = gpeEvents[pmfr_pkg::GPE_EC] | ecEvent;
    end

    // one sticky cell per implemented status bit, cleared by writing a one there
    genvar gi;
    generate
        for (gi = 0; gi < pmfr_pkg::FIX_W; gi++) begin : g_fix
            if (pmfr_pkg::FIX_STS_IMPL[gi]) begin : g_impl
                pmfr_status_cell u_cell (
                    .ref_clk(ref_clk),
                    .sys_rst(sys_rst),
                    .eventIn(fixEvents[gi]),
                    .clearOne(fixStsWr.strobe & fixStsWr.data[gi]),
                    .status(fixStsRaw[gi])
                );
            end else begin : g_rsvd
                assign fixStsRaw[gi] = 1'b0;
            end
        end
        for (gi = 0; gi < pmfr_pkg::GPE_W; gi++) begin : g_gpe
            pmfr_status_cell u_cell (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .eventIn(gpeAll[gi]),
                .clearOne(gpeStsWr.strobe & gpeStsWr.data[gi]),
                .status(gpeStsRaw[gi])
            );
        end
    endgenerate

    // enables: a single write takes effect at once, no unlock sequence
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fixEnReg <= pmfr_pkg::FIX_RESET;
        end else if (fixEnWr.strobe) begin
            fixEnReg <= fixEnWr.data & pmfr_pkg::FIX_EN_IMPL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gpeEnReg <= pmfr_pkg::GPE_RESET;
        end else if (gpeEnWr.strobe) begin
            gpeEnReg <= gpeEnWr.data;
        end
    end

    // control: only implemented bits are stored, write-only bit never is
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctlReg <= pmfr_pkg::CTL_RESET;
            ctlReg[pmfr_pkg::CTL_MODE] <= ACPI_ONLY;
        end else if (ctlWr.strobe) begin
            ctlReg <= ctlWr.data & pmfr_pkg::CTL_STORE_MASK;
        end
    end

    // the sleep command fires only on a written one; a zero does nothing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sleepStart <= 1'b0;
        end else begin
            sleepStart <= ctlWr.strobe & ctlWr.data[pmfr_pkg::CTL_SLPEN];
        end
    end

    // read views: reserved positions are zero, write-only reads back zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fixSts <= '0;
            fixEn <= '0;
            ctlRead <= '0;
            gpeSts <= '0;
            gpeEn <= '0;
        end else begin
            fixSts <= fixStsRaw & pmfr_pkg::FIX_STS_IMPL;
            fixEn <= fixEnReg;
            ctlRead <= ctlReg;
            gpeSts <= gpeStsRaw;
            gpeEn <= gpeEnReg;
        end
    end

    assign acpi_mode_select = ctlReg[pmfr_pkg::CTL_MODE];
    assign sleepType = ctlReg[pmfr_pkg::CTL_SLPTYP_LO +: pmfr_pkg::CTL_SLPTYP_W];

    // enable only gates the output, never the status bit itself
    assign anyEvent = |(fixStsRaw & fixEnReg) | |(gpeStsRaw & gpeEnReg);

    // interrupt steering by mode; only this block's own lines are touched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            smiReq <= 1'b0;
            sciReq <= 1'b0;
            rtcWake <= 1'b0;
        end else begin
            smiReq <= anyEvent & ~ctlReg[pmfr_pkg::CTL_MODE];
            sciReq <= anyEvent & ctlReg[pmfr_pkg::CTL_MODE];
            rtcWake <= fixStsRaw[pmfr_pkg::FIX_RTC] & fixEnReg[pmfr_pkg::FIX_RTC];
        end
    end

    // millisecond enable pulse for the override hold count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tickCount <= '0;
        end else if (tickCount == 32'(TICK_CYCLES - 1)) begin
            tickCount <= '0;
        end else begin
            tickCount <= tickCount + 32'h1;
        end
    end
    assign msTick = (tickCount == 32'(TICK_CYCLES - 1));

    // override is pure hardware so it works when software is hung
    always_comb begin
        next_ovrState = ovrState;
        unique case (ovrState)
            pmfr_pkg::OVR_IDLE: begin
                if (pwrBtnPressed) begin
                    next_ovrState = pmfr_pkg::OVR_COUNT;
                end
            end
            pmfr_pkg::OVR_COUNT: begin
                if (!pwrBtnPressed) begin
                    next_ovrState = pmfr_pkg::OVR_IDLE;
                end else if (msTick && holdTicks == 32'(OVR_TICKS - 1)) begin
                    next_ovrState = pmfr_pkg::OVR_OFF;
                end
            end
            pmfr_pkg::OVR_OFF: begin
                next_ovrState = pmfr_pkg::OVR_OFF;
            end
            default: begin
                next_ovrState = pmfr_pkg::OVR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ovrState <= pmfr_pkg::OVR_IDLE;
        end else begin
            ovrState <= next_ovrState;
        end
    end

    // hold count restarts whenever the button lets go
    always_ff @(posedge ref_clk) begin
        if (sys_rst || ovrState != pmfr_pkg::OVR_COUNT || !pwrBtnPressed) begin
            holdTicks <= '0;
        end else if (msTick) begin
            holdTicks <= holdTicks + 32'h1;
        end
    end

    // latched until reset: a release after the cut must not power back up
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            forceOff <= 1'b0;
        end else if (next_ovrState == pmfr_pkg::OVR_OFF) begin
            forceOff <= 1'b1;
        end
    end
endmodule

// ### verif/pmfr_sva.sv
`timescale 1ns/1ps
module pmfr_sva #(
    parameter longint TICK_CYCLES = 4,
    parameter longint OVR_TICKS = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic pwrBtnPressed,
    input wire logic pwrBtnEvent,
    input pmfr_pkg::pmfr_wr16_s ctlWr,
    input wire logic [15:0] fixSts,
    input wire logic [15:0] fixEn,
    input wire logic [15:0] ctlRead,
    input wire logic [23:0] timerValue,
    input wire logic acpi_mode_select,
    input wire logic sleepStart,
    input wire logic forceOff,
    input wire logic smiReq,
    input wire logic sciReq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    longint holdCnt;
    // length of the current press; any release restarts the count
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !pwrBtnPressed) begin
            holdCnt <= 0;
        end else begin
            holdCnt <= holdCnt + 1;
        end
    end
    a_rsv_zero: assert property (
        (fixSts & ~pmfr_pkg::FIX_STS_IMPL) == 16'h0000 && (fixEn & ~pmfr_pkg::FIX_EN_IMPL) == 16'h0000
        && (ctlRead & ~pmfr_pkg::CTL_STORE_MASK) == 16'h0000) else $error("reserved bit set");
    a_mode_take: assert property (
        ctlWr.strobe |=> acpi_mode_select == $past(ctlWr.data[0])) else $error("mode bit wrong");
    a_slp_go: assert property (
        ctlWr.strobe && ctlWr.data[13] |=> sleepStart) else $error("no sleep start");
    a_slp_zero: assert property (
        !(ctlWr.strobe && ctlWr.data[13]) |=> !sleepStart) else $error("stray sleep start");
    a_sts_set: assert property (
        pwrBtnEvent |=> ##1 fixSts[8]) else $error("status not set");
    a_route_sci: assert property (
        sciReq |-> $past(acpi_mode_select)) else $error("sci in legacy");
    a_route_smi: assert property (
        smiReq |-> !$past(acpi_mode_select)) else $error("smi in advanced");
    // the timer may hold or step by one, never jump
    a_tmr_step: assert property (
        timerValue != $past(timerValue) |-> timerValue == $past(timerValue) + 24'h000001)
        else $error("timer jumped");
    a_ovr_hold: assert property (
        holdCnt >= (OVR_TICKS + 1) * TICK_CYCLES + 3 |-> forceOff) else $error("no force off");
endmodule
bind pmfr_top pmfr_sva #(.TICK_CYCLES(TICK_CYCLES), .OVR_TICKS(OVR_TICKS)) u_pmfr_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .pwrBtnPressed(pwrBtnPressed),
    .pwrBtnEvent(pwrBtnEvent), .ctlWr(ctlWr), .fixSts(fixSts), .fixEn(fixEn),
    .ctlRead(ctlRead), .timerValue(timerValue), .acpi_mode_select(acpi_mode_select),
    .sleepStart(sleepStart), .forceOff(forceOff), .smiReq(smiReq), .sciReq(sciReq));

// ### verif/tb_pmfr_top.sv
`timescale 1ns/1ps
module tb_pmfr_top;
    logic ref_clk = 0;
    logic sys_rst = 1;
    logic pwrBtnPressed = 0;
    logic ecEvent = 0;
    logic [3:0] evt = 0;
    logic [7:0] gpeEvents = 0;
    pmfr_pkg::pmfr_wr16_s fixStsWr = '0, fixEnWr = '0, ctlWr = '0;
    pmfr_pkg::pmfr_wr8_s gpeStsWr = '0, gpeEnWr = '0;
    logic [15:0] fixSts, fixEn, ctlRead;
    logic [7:0] gpeSts, gpeEn;
    logic [23:0] timerValue, t0;
    logic [2:0] sleepType;
    logic acpi_mode_select, sleepStart, rtcWake, forceOff, smiReq, sciReq;
    logic [15:0] bits [4] = '{16'h0100, 16'h0200, 16'h0400, 16'h8000};
    int miscompares = 0, n_checks = 0;
    // short tick and hold counts keep the override test brief
    pmfr_top #(.TICK_CYCLES(4), .OVR_TICKS(3)) u_pmfr_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .pwrBtnPressed(pwrBtnPressed), .pwrBtnEvent(evt[0]), .slpBtnEvent(evt[1]),
        .rtcAlarmEvent(evt[2]), .wakeEvent(evt[3]), .ecEvent(ecEvent), .gpeEvents(gpeEvents),
        .fixStsWr(fixStsWr), .fixEnWr(fixEnWr), .ctlWr(ctlWr), .gpeStsWr(gpeStsWr),
        .gpeEnWr(gpeEnWr), .fixSts(fixSts), .fixEn(fixEn), .ctlRead(ctlRead), .gpeSts(gpeSts),
        .gpeEn(gpeEn), .timerValue(timerValue), .acpi_mode_select(acpi_mode_select),
        .sleepType(sleepType), .sleepStart(sleepStart), .rtcWake(rtcWake),
        .forceOff(forceOff), .smiReq(smiReq), .sciReq(sciReq));
    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one-cycle strobe; returns at the falling edge after the write edge
    task automatic wr(input int p, input logic [15:0] d);
        @(negedge ref_clk);
        case (p)
            0: fixStsWr <= '{1'b1, d};
            1: fixEnWr <= '{1'b1, d};
            2: ctlWr <= '{1'b1, d};
            3: gpeStsWr <= '{1'b1, d[7:0]};
            default: gpeEnWr <= '{1'b1, d[7:0]};
        endcase
        @(negedge ref_clk);
        {fixStsWr.strobe, fixEnWr.strobe, ctlWr.strobe, gpeStsWr.strobe, gpeEnWr.strobe} <= '0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        int n;
        cyc(12);
        sys_rst <= 0;
        cyc(1);
        chk(ctlRead, 0);
        chk(acpi_mode_select, 0);
        $display("reset test done");
        // all ones: reserved bits must drop, write-only bit fires once
        wr(2, 16'hffff);
        chk(sleepStart, 1);
        chk(acpi_mode_select, 1);
        cyc(1);
        chk(sleepStart, 0);
        chk(ctlRead, 16'h1c01);
        chk(sleepType, 3'h7);
        wr(2, 16'h1c00);
        chk(sleepStart, 0);
        chk(acpi_mode_select, 0);
        wr(2, 16'h0001);
        wr(1, 16'hffff);
        wr(4, 16'h00ff);
        cyc(1);
        chk(fixEn, 16'h0701);
        chk(gpeEn, 8'hff);
        $display("control test done");
        // each button, alarm and wake event in advanced mode; only enabled ones request
        for (int i = 0; i < 4; i++) begin
            evt[i] <= 1;
            cyc(1);
            evt[i] <= 0;
            cyc(1);
            chk(fixSts, bits[i]);
            chk(sciReq, i < 3);
            chk(smiReq, 0);
            chk(rtcWake, i == 2);
            wr(0, ~bits[i]);
            cyc(1);
            chk(fixSts, bits[i]);
            wr(0, bits[i]);
            cyc(1);
            chk(fixSts, 0);
        end
        $display("event test done");
        // legacy mode steers to the management interrupt
        // read-modify-write: keep read-back fields, drop write-only and mode bits
        wr(2, ctlRead & 16'hdffe);
        evt[1] <= 1;
        ecEvent <= 1;
        gpeEvents <= 8'h20;
        cyc(1);
        {evt[1], ecEvent, gpeEvents} <= '0;
        cyc(1);
        chk(gpeSts, 8'h21);
        chk(smiReq, 1);
        chk(sciReq, 0);
        wr(0, 16'h0200);
        wr(3, 16'h0021);
        cyc(1);
        chk(gpeSts, 0);
        chk(smiReq, 0);
        $display("routing test done");
        t0 = timerValue;
        cyc(112);
        chk(timerValue, t0 + 24'd2);
        $display("timer test done");
        // a short press must not count; a long one forces off and sticks
        pwrBtnPressed <= 1;
        cyc(6);
        chk(forceOff, 0);
        pwrBtnPressed <= 0;
        cyc(2);
        pwrBtnPressed <= 1;
        for (n = 0; n < 40 && forceOff !== 1'b1; n++) cyc(1);
        chk(n >= 8 && n <= 20, 1);
        // keep holding eight more cycles, still short of the checker's hold bound
        cyc(8);
        chk(forceOff, 1);
        pwrBtnPressed <= 0;
        cyc(3);
        chk(forceOff, 1);
        $display("override test done");
        final_report();
    end
endmodule
